// *** core/eim_pkg.sv ***
// Constants and types for the EEPROM master with MDIO access window
package eim_pkg;
    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // ========================================================
    // Two-wire bus
    localparam logic [3:0] DSEL_FIXED = 4'b1010;
    localparam int         EE_ADDR_BITS = 16;
    // ========================================================
    // Management frame
    localparam logic [1:0] OPF_RD    = 2'b10;
    localparam logic [1:0] OPF_WR    = 2'b01;
    localparam int         HDR_LAST  = 11;
    localparam int         DATA_LAST = 15;
    // ========================================================
    // Management register map
    localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
    localparam logic [4:0] REG_MMD_DATA = 5'h0E;
    localparam logic [4:0] REG_EE_CTRL  = 5'h1C;
    localparam logic [4:0] MMD_DEV_EE   = 5'h1E;
    localparam logic [1:0] MMD_FN_ADDR  = 2'b00;
    localparam int         MMD_FN_LSB   = 14;
    localparam int         CW_EXEC      = 0;
    localparam int         CW_READ      = 1;
    localparam int         CW_DET       = 2;
    localparam logic [15:0] MMD_CTRL_RST = 16'h0000;
    // ========================================================
    // Jobs
    typedef enum logic [1:0] {EIM_OP_PROBE, EIM_OP_WRITE, EIM_OP_READ, EIM_OP_BURST} eim_op_e;
    typedef struct packed {
        eim_op_e     op;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [15:0] len;
    } eim_job_s;
endpackage

// *** core/eim_top.sv ***
// EEPROM two-wire master with 16-bit addressing and MDIO indirect window
// Summary of operation
// - Memory address goes out as two bytes, high byte first, then low.
// - Sizes 32 kb to 512 kb; unused upper address bits sent as zero.
// - Low three device select bits come from the soft strap.
// - Instruction byte is 1010, three strap bits, then read/write bit.
// - Writes are always instruction, two address bytes, one data, stop.
// - Start pulls data low with clock high; stop releases it high.
// - Reads start as dummy write, repeated start, instruction with read.
// - Single read leaves data unacknowledged and then sends a stop.
// - Burst reads ack every byte but the last, which ends with stop.
// - Bursts only for firmware load; configuration uses single bytes.
// - Host accesses through management are single bytes only.
// - Whole EEPROM is mapped into indirect device 1E address space.
// - Host writes address, data and control; device then stores alone.
// - Host polls execute flag after a read, then fetches the data.
// - Detection flag is set when an EEPROM answers the probe.
// - Data pin is driven by host or device depending on frame type.
// - Management uses only a clock and one bidirectional data line.
// - Operation field is 10 for read and 01 for write.
// - Read turnaround: release first bit time, drive zero second.
// - Frames are accepted with no preamble or ones of any length.
`timescale 1ns/1ps
module eim_top #(
    parameter int QTR       = eim_pkg::QTR_CYC,
    parameter int ADDR_BITS = eim_pkg::EE_ADDR_BITS
) (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Straps
    input  wire logic [2:0]  dev_sel_strap,
    input  wire logic [4:0]  port_addr_strap,
    // Two-wire EEPROM bus
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Management link
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    // Firmware burst port
    input  wire logic        fw_req,
    input  wire logic [15:0] fw_addr,
    input  wire logic [15:0] fw_len,
    output logic [7:0]       fw_data,
    output logic             fw_valid,
    output logic             fw_done,
    output logic             fw_nack,
    // Status
    output logic             eeprom_detected_flag,
    output logic             busy
);
    typedef enum {I_IDLE, I_START, I_TX, I_RX, I_STOP} eim_i2c_e;
    typedef enum {M_IDLE, M_ST, M_HDR, M_TA, M_DATA} eim_mdio_e;

    localparam logic [15:0] AMASK = 16'((17'd1 << ADDR_BITS) - 17'd1);

    // ========================================================
    // System domain state
    logic [4:0]  pin_m_ff, pin_s_ff;
    logic [2:0]  rq_ff;
    logic        dn_tgl_ff, hp_ff, probe_ff, det_ff;
    eim_i2c_e    st_ff;
    eim_pkg::eim_job_s job_ff;
    logic [15:0] q_ff;
    logic [1:0]  ph_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  sh_ff, rd_ff;
    logic [2:0]  seq_ff;
    logic        nack_ff, err_ff, scl_oe_ff, sda_oe_ff;
    logic        tick, sda_s, scl_s, host_ev;
    logic [2:0]  dsel_s;

    // ========================================================
    // Management domain state
    logic        mr_m_ff, mr_s_ff;
    logic [4:0]  pa_m_ff, pa_s_ff;
    logic [1:0]  dt_ff;
    logic [2:0]  dn_ff;
    eim_mdio_e   ms_ff;
    logic [4:0]  mc_ff;
    logic [11:0] hdr_ff;
    logic [15:0] wsh_ff, osh_ff, mctl_ff, eaddr_ff, rdval;
    logic [7:0]  ewd_ff;
    logic        erd_ff, ex_ff, rq_tgl_ff, mo_ff, moe_ff;
    logic        mine, is_rd, wr_go;
    logic [15:0] wr_word;

    // Pin synchronisers: scl, sda and strap pass two flops
    always_ff @(posedge clk) begin
        pin_m_ff <= {scl_in, sda_in, dev_sel_strap};
        pin_s_ff <= pin_m_ff;
    end
    assign scl_s  = pin_s_ff[4];
    assign sda_s  = pin_s_ff[3];
    assign dsel_s = pin_s_ff[2:0];

    // Request toggle from the management domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rq_ff <= 3'b000;
        end else begin
            rq_ff <= {rq_ff[1], rq_ff[0], rq_tgl_ff};
        end
    end
    assign host_ev = rq_ff[2] ^ rq_ff[1];

    // Quarter-bit timer; holds while a slave stretches the clock
    assign tick = (q_ff == 16'(QTR - 1));
    always_ff @(posedge clk) begin
        if (!rst_n || st_ff == I_IDLE || tick) begin
            q_ff <= 16'h0000;
        end else if (!(ph_ff == 2'd2 && !scl_oe_ff && !scl_s)) begin
            q_ff <= q_ff + 16'h0001;
        end
    end

    // Pending host job and post-reset probe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hp_ff    <= 1'b0;
            probe_ff <= 1'b1;
        end else begin
            if (host_ev) begin
                hp_ff <= 1'b1;
            end else if (st_ff == I_IDLE && !probe_ff && !(fw_req && fw_len != 16'h0000)) begin
                hp_ff <= 1'b0;
            end
            if (st_ff == I_IDLE) begin
                probe_ff <= 1'b0;
            end
        end
    end

    // Byte to send for each step of the frame
    localparam logic [3:0] DSEL_FIXED_W = eim_pkg::DSEL_FIXED;
    function automatic logic [7:0] tx_byte(input logic [2:0] s, input eim_pkg::eim_job_s j,
                                           input logic [2:0] ds);
        logic [15:0] a;
        a = j.addr & AMASK;
        case (s)
            3'd0:    tx_byte = {DSEL_FIXED_W, ds, 1'b0};
            3'd1:    tx_byte = a[15:8];
            3'd2:    tx_byte = a[7:0];
            3'd3:    tx_byte = j.wdata;
            default: tx_byte = {DSEL_FIXED_W, ds, 1'b1};
        endcase
    endfunction

    // Two-wire frame engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff     <= I_IDLE;
            job_ff    <= '0;
            ph_ff     <= 2'd0;
            bit_ff    <= 4'd0;
            sh_ff     <= 8'h00;
            seq_ff    <= 3'd0;
            nack_ff   <= 1'b0;
            err_ff    <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            rd_ff     <= 8'h00;
            det_ff    <= 1'b0;
            dn_tgl_ff <= 1'b0;
            fw_data   <= 8'h00;
            fw_valid  <= 1'b0;
            fw_done   <= 1'b0;
            fw_nack   <= 1'b0;
        end else begin
            fw_valid <= 1'b0;
            fw_done  <= 1'b0;
            if (st_ff == I_IDLE) begin
                ph_ff  <= 2'd0;
                seq_ff <= 3'd0;
                err_ff <= 1'b0;
                if (probe_ff) begin
                    job_ff <= '{eim_pkg::EIM_OP_PROBE, 16'h0000, 8'h00, 16'h0001};
                    st_ff  <= I_START;
                end else if (fw_req && fw_len != 16'h0000) begin
                    job_ff <= '{eim_pkg::EIM_OP_BURST, fw_addr, 8'h00, fw_len};
                    st_ff  <= I_START;
                end else if (hp_ff) begin
                    job_ff.op    <= erd_ff ? eim_pkg::EIM_OP_READ : eim_pkg::EIM_OP_WRITE;
                    job_ff.addr  <= eaddr_ff;
                    job_ff.wdata <= ewd_ff;
                    job_ff.len   <= 16'h0001;
                    st_ff        <= I_START;
                end
            end else if (tick) begin
                ph_ff <= ph_ff + 2'd1;
                case (st_ff)
                    // Start or repeated start
                    I_START: begin
                        case (ph_ff)
                            2'd0: sda_oe_ff <= 1'b0;
                            2'd1: scl_oe_ff <= 1'b0;
                            2'd2: sda_oe_ff <= 1'b1;
                            default: begin
                                scl_oe_ff <= 1'b1;
                                bit_ff    <= 4'd0;
                                sh_ff     <= tx_byte(seq_ff, job_ff, dsel_s);
                                st_ff     <= I_TX;
                            end
                        endcase
                    end
                    // Send a byte, then sample the acknowledge
                    I_TX: begin
                        case (ph_ff)
                            2'd0: sda_oe_ff <= (bit_ff == 4'd8) ? 1'b0 : !sh_ff[7];
                            2'd1: scl_oe_ff <= 1'b0;
                            2'd2: nack_ff   <= sda_s;
                            default: begin
                                scl_oe_ff <= 1'b1;
                                bit_ff    <= bit_ff + 4'd1;
                                sh_ff     <= {sh_ff[6:0], 1'b0};
                                if (bit_ff == 4'd8) begin
                                    bit_ff <= 4'd0;
                                    seq_ff <= seq_ff + 3'd1;
                                    sh_ff  <= tx_byte(seq_ff + 3'd1, job_ff, dsel_s);
                                    if (job_ff.op == eim_pkg::EIM_OP_PROBE) begin
                                        det_ff <= !nack_ff;
                                        st_ff  <= I_STOP;
                                    end else if (nack_ff) begin
                                        err_ff <= 1'b1;
                                        st_ff  <= I_STOP;
                                    end else if (seq_ff == 3'd3) begin
                                        st_ff <= I_STOP;
                                    end else if (seq_ff == 3'd4) begin
                                        st_ff <= I_RX;
                                    end else if (seq_ff == 3'd2 &&
                                                 job_ff.op != eim_pkg::EIM_OP_WRITE) begin
                                        seq_ff <= 3'd4; // Skip data step, resend read instruction
                                        st_ff <= I_START;
                                    end
                                end
                            end
                        endcase
                    end
                    // Receive a byte, then ack or not
                    I_RX: begin
                        case (ph_ff)
                            2'd0: sda_oe_ff <= (bit_ff == 4'd8) && (job_ff.len != 16'h0001);
                            2'd1: scl_oe_ff <= 1'b0;
                            2'd2: if (bit_ff != 4'd8) sh_ff <= {sh_ff[6:0], sda_s};
                            default: begin
                                scl_oe_ff <= 1'b1;
                                bit_ff    <= bit_ff + 4'd1;
                                if (bit_ff == 4'd7) begin
                                    if (job_ff.op == eim_pkg::EIM_OP_BURST) begin
                                        fw_data  <= sh_ff;
                                        fw_valid <= 1'b1;
                                    end else begin
                                        rd_ff <= sh_ff;
                                    end
                                end
                                if (bit_ff == 4'd8) begin
                                    bit_ff     <= 4'd0;
                                    job_ff.len <= job_ff.len - 16'h0001;
                                    if (job_ff.len == 16'h0001) begin
                                        st_ff <= I_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                    // Stop and report completion
                    I_STOP: begin
                        case (ph_ff)
                            2'd0: sda_oe_ff <= 1'b1;
                            2'd1: scl_oe_ff <= 1'b0;
                            2'd2: sda_oe_ff <= 1'b0;
                            default: begin
                                st_ff <= I_IDLE;
                                if (job_ff.op == eim_pkg::EIM_OP_BURST) begin
                                    fw_done <= 1'b1;
                                    fw_nack <= err_ff;
                                end else if (job_ff.op != eim_pkg::EIM_OP_PROBE) begin
                                    dn_tgl_ff <= !dn_tgl_ff;
                                end
                            end
                        endcase
                    end
                    default: st_ff <= I_IDLE;
                endcase
            end
        end
    end

    // Open-drain drivers only ever pull low
    assign scl_out              = 1'b0;
    assign sda_out              = 1'b0;
    assign scl_oe               = scl_oe_ff;
    assign sda_oe               = sda_oe_ff;
    assign busy                 = (st_ff != I_IDLE);
    assign eeprom_detected_flag = det_ff;

    // ========================================================
    // Management domain, clocked only by the host clock
    // Reset, strap, detection and completion synchronisers
    always_ff @(posedge mdc) begin
        mr_m_ff <= rst_n;
        mr_s_ff <= mr_m_ff;
        pa_m_ff <= port_addr_strap;
        pa_s_ff <= pa_m_ff;
        dt_ff   <= {dt_ff[0], det_ff};
        dn_ff   <= {dn_ff[1], dn_ff[0], dn_tgl_ff};
    end

    // Frame decode
    assign mine    = (hdr_ff[9:5] == pa_s_ff);
    assign is_rd   = (hdr_ff[11:10] == eim_pkg::OPF_RD);
    assign wr_word = {wsh_ff[14:0], mdio_in};
    assign wr_go   = (ms_ff == M_DATA) && (mc_ff == 5'(eim_pkg::DATA_LAST)) && mine &&
                     (hdr_ff[11:10] == eim_pkg::OPF_WR);

    // Read value for the addressed register
    always_comb begin
        rdval = 16'h0000;
        case (hdr_ff[4:0])
            eim_pkg::REG_MMD_CTRL: rdval = mctl_ff;
            eim_pkg::REG_MMD_DATA: begin
                if (mctl_ff[4:0] == eim_pkg::MMD_DEV_EE) begin
                    if (mctl_ff[15:eim_pkg::MMD_FN_LSB] == eim_pkg::MMD_FN_ADDR) begin
                        rdval = eaddr_ff;
                    end else begin
                        rdval = {8'h00, rd_ff};
                    end
                end
            end
            eim_pkg::REG_EE_CTRL: rdval = {13'h0000, dt_ff[1], erd_ff, ex_ff};
            default: rdval = 16'h0000;
        endcase
    end

    // Frame receiver and read driver
    always_ff @(posedge mdc) begin
        if (!mr_s_ff) begin
            ms_ff  <= M_IDLE;
            mc_ff  <= 5'd0;
            hdr_ff <= 12'h000;
            wsh_ff <= 16'h0000;
            osh_ff <= 16'h0000;
            mo_ff  <= 1'b1;
            moe_ff <= 1'b0;
        end else begin
            mc_ff <= mc_ff + 5'd1;
            case (ms_ff)
                M_IDLE: begin
                    if (!mdio_in) ms_ff <= M_ST;
                end
                M_ST: begin
                    mc_ff <= 5'd0;
                    ms_ff <= mdio_in ? M_HDR : M_ST;
                end
                M_HDR: begin
                    hdr_ff <= {hdr_ff[10:0], mdio_in};
                    if (mc_ff == 5'(eim_pkg::HDR_LAST)) begin
                        mc_ff <= 5'd0;
                        ms_ff <= M_TA;
                    end
                end
                M_TA: begin
                    if (mine && is_rd) begin
                        moe_ff <= 1'b1;
                        mo_ff  <= (mc_ff == 5'd0) ? 1'b0 : rdval[15];
                        osh_ff <= {rdval[14:0], 1'b0};
                    end
                    if (mc_ff == 5'd1) begin
                        mc_ff <= 5'd0;
                        ms_ff <= M_DATA;
                    end
                end
                M_DATA: begin
                    wsh_ff <= wr_word;
                    mo_ff  <= osh_ff[15];
                    osh_ff <= {osh_ff[14:0], 1'b0};
                    if (mc_ff == 5'(eim_pkg::DATA_LAST)) begin
                        moe_ff <= 1'b0;
                        mo_ff  <= 1'b1;
                        ms_ff  <= M_IDLE;
                    end
                end
                default: ms_ff <= M_IDLE;
            endcase
        end
    end
    assign mdio_out = mo_ff;
    assign mdio_oe  = moe_ff;

    // Register writes from the host
    always_ff @(posedge mdc) begin
        if (!mr_s_ff) begin
            mctl_ff  <= eim_pkg::MMD_CTRL_RST;
            eaddr_ff <= 16'h0000;
            ewd_ff   <= 8'h00;
        end else if (wr_go) begin
            if (hdr_ff[4:0] == eim_pkg::REG_MMD_CTRL) begin
                mctl_ff <= wr_word;
            end else if (hdr_ff[4:0] == eim_pkg::REG_MMD_DATA &&
                         mctl_ff[4:0] == eim_pkg::MMD_DEV_EE && !ex_ff) begin
                if (mctl_ff[15:eim_pkg::MMD_FN_LSB] == eim_pkg::MMD_FN_ADDR) begin
                    eaddr_ff <= wr_word;
                end else begin
                    ewd_ff <= wr_word[7:0];
                end
            end
        end
    end

    // Execute flag and request handshake
    always_ff @(posedge mdc) begin
        if (!mr_s_ff) begin
            ex_ff     <= 1'b0;
            erd_ff    <= 1'b0;
            rq_tgl_ff <= 1'b0;
        end else begin
            if (dn_ff[2] ^ dn_ff[1]) begin
                ex_ff <= 1'b0;
            end
            if (wr_go && hdr_ff[4:0] == eim_pkg::REG_EE_CTRL &&
                wr_word[eim_pkg::CW_EXEC] && !ex_ff) begin
                ex_ff     <= 1'b1;
                erd_ff    <= wr_word[eim_pkg::CW_READ];
                rq_tgl_ff <= !rq_tgl_ff;
            end
        end
    end
endmodule

// *** dv/eim_top_asserts.sv ***
// Port checks for the EEPROM master
`timescale 1ns/1ps
module eim_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and status
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic fw_valid,
    input wire logic fw_done,
    input wire logic fw_nack,
    input wire logic busy,
    input wire logic eeprom_detected_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Bus framing and burst handshake
    start_a: assert property ($rose(sda_oe) && !scl_oe |-> sda_oe throughout (##[1:20] scl_oe))
        else $error("start not followed by clock low");
    stop_a: assert property ($fell(sda_oe) && !scl_oe |-> !scl_oe [*4])
        else $error("stop not held");
    idle_a: assert property (!busy && !$past(busy) |-> !scl_oe && !sda_oe)
        else $error("lines pulled while idle");
    fwv_busy_a: assert property (fw_valid |-> busy)
        else $error("byte outside burst");
    fw_done_a: assert property (fw_done |=> !fw_done && !busy)
        else $error("burst end not one cycle");
    fw_gap_a: assert property (fw_valid |=> !fw_valid [*8])
        else $error("bytes too close");
    nack_upd_a: assert property ($changed(fw_nack) |-> fw_done)
        else $error("nack moved without done");
    det_hold_a: assert property (eeprom_detected_flag |=> eeprom_detected_flag)
        else $error("detected flag dropped");
    cover property (fw_done);
    cover property ($rose(eeprom_detected_flag));
    cover property ($fell(sda_oe) && !scl_oe);
endmodule
bind eim_top eim_top_asserts u_chk (.clk, .rst_n, .scl_oe, .sda_oe, .fw_valid, .fw_done,
    .fw_nack, .busy, .eeprom_detected_flag);

// *** dv/eim_ee_model.sv ***
// Behavioural two-wire EEPROM answering one device select
`timescale 1ns/1ps
module eim_ee_model (
    // Bus and configuration
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [2:0] sel,
    input  wire logic       absent,
    // Data pull-down
    output logic            sda_oe
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  sh;
    logic [15:0] adr;
    logic        rd, tx;
    int          bitn, nb;
    initial sda_oe = 1'b0;
    initial nb = -1;
    // Start opens a frame, stop closes it
    always @(negedge sda) if (scl) {bitn, nb, tx} = '0;
    always @(posedge sda) if (scl) nb = -1;
    // Shift in master bits; after a sent byte take the master answer
    always @(posedge scl) if (nb >= 0) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        if (bitn < 8) bitn++;
        else if (tx && sda) nb = -1;
        else if (tx) adr++;
    end
    // Acknowledge, store and send bytes while the clock is low
    always @(negedge scl) if (nb >= 0) begin
        if (bitn == 8 && tx) sda_oe = 1'b0;
        if (bitn == 8 && !tx && nb == 0) rd = sh[0];
        if (bitn == 8 && !tx && nb == 0 && (absent || sh[7:1] != {4'b1010, sel})) nb = -1;
        if (bitn == 8 && !tx && nb == 1) adr[15:8] = sh;
        if (bitn == 8 && !tx && nb == 2) adr[7:0] = sh;
        if (bitn == 8 && !tx && nb == 3) mem[adr] = sh;
        if (bitn == 8 && !tx) sda_oe = (nb >= 0);
        if (bitn == 9) begin
            nb++;
            tx     = rd;
            sda_oe = rd & ~mem[adr][7];
        end else if (tx && bitn < 8) sda_oe = ~mem[adr][7 - bitn];
        bitn = (bitn == 8) ? 9 : (bitn == 9) ? 0 : bitn;
    end
endmodule

// *** dv/eim_top_tb.sv ***
// Self-checking bench for the EEPROM master
`timescale 1ns/1ps
module eim_top_tb;
    logic        clk, rst_n, mdc, mh, mh_oe, fw_req, absent;
    logic        scl_oe, sda_oe, ee_oe, mdio_out, mdio_oe, fw_valid, fw_done, fw_nack, det, busy;
    logic [15:0] fw_addr, fw_len, r;
    logic [7:0]  fw_data;
    logic [2:0]  ds;
    int          n_mismatch, compares;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | ee_oe);
    wire         mdio = mdio_oe ? mdio_out : (mh_oe ? mh : 1'b1);
    eim_top #(.QTR(4), .ADDR_BITS(16)) dut (.clk(clk), .rst_n(rst_n), .dev_sel_strap(ds),
        .port_addr_strap(5'h03), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .fw_req(fw_req), .fw_addr(fw_addr), .fw_len(fw_len),
        .fw_data(fw_data), .fw_valid(fw_valid), .fw_done(fw_done), .fw_nack(fw_nack),
        .eeprom_detected_flag(det), .busy(busy));
    eim_ee_model u_ee (.scl(scl), .sda(sda), .sel(3'b101), .absent(absent), .sda_oe(ee_oe));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    endtask
    task automatic summarize();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [7:0] ex(input logic [15:0] a);
        return (a == 16'h1234) ? 8'ha5 : a[7:0] ^ a[15:8];
    endfunction
    // One management frame, host side, optional preamble
    task automatic mf(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, int pre);
        logic [31:0] f;
        f = {2'b01, op, 5'h03, ra, 2'b10, wd};
        for (int i = -pre; i < 32; i++) begin
            mh_oe = !(op == eim_pkg::OPF_RD && i >= 14);
            mh = (i < 0) ? 1'b1 : f[31 - i];
            #3;
            if (i == 14 && !mh_oe) chk("ta_release", 16'h0000, {15'h0, mdio_oe});
            if (i == 15 && !mh_oe) chk("ta_zero", 16'h0000, {15'h0, mdio});
            if (i >= 16) r = {r[14:0], mdio};
            mdc = 1'b1;
            #3;
            mdc = 1'b0;
        end
        mh_oe = 1'b0;
        #20;
    endtask
    // Host byte access through the indirect window, then wait on execute
    task automatic ee_op(input logic [15:0] a, input logic [7:0] d, input logic rdo, int pre);
        mf(2'b01, 5'h0D, 16'h001E, pre);
        mf(2'b01, 5'h0E, a, 0);
        mf(2'b01, 5'h0D, 16'h401E, 0);
        if (!rdo) mf(2'b01, 5'h0E, {8'h00, d}, 0);
        mf(2'b01, 5'h1C, {14'h0000, rdo, 1'b1}, 0);
        mf(2'b10, 5'h1C, 16'h0000, 0);
        chk("exec_set", 16'h0001, {15'h0, r[0]});
        for (int k = 0; k < 300 && r[0] !== 1'b0; k++) mf(2'b10, 5'h1C, 16'h0000, 0);
        chk("exec_clear", 16'h0000, {15'h0, r[0]});
        if (rdo) mf(2'b10, 5'h0E, 16'h0000, 0);
        $display("test host access done");
    endtask
    // Reset, then let the probe finish
    task automatic do_reset(input logic a);
        absent = a;
        rst_n  = 1'b0;
        repeat (20) @(negedge clk) mdc = ~mdc;
        rst_n = 1'b1;
        repeat (4) @(negedge clk) mdc = ~mdc;
        repeat (600) @(negedge clk);
        chk("probe_end", 16'h0000, {15'h0, busy});
        chk("detected", {15'h0, ~a}, {15'h0, det});
        $display("test reset done");
    endtask
    // Three-byte firmware burst
    task automatic burst(input logic [15:0] a, input logic nk);
        int n;
        n = 0;
        @(negedge clk);
        {fw_addr, fw_len, fw_req} = {a, 16'h0003, 1'b1};
        @(negedge clk);
        fw_req = 1'b0;
        for (int k = 0; k < 4000 && fw_done !== 1'b1; k++) begin
            @(negedge clk);
            if (fw_valid === 1'b1) chk("fw_byte", {8'h00, ex(a + n[15:0])}, {8'h00, fw_data});
            if (fw_valid === 1'b1) n++;
        end
        chk("fw_count", nk ? 16'h0000 : 16'h0003, n[15:0]);
        chk("fw_nack", {15'h0, nk}, {15'h0, fw_nack});
        $display("test burst done");
    endtask
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000 n_mismatch++;
        summarize();
    end
    // Main sequence
    initial begin
        {rst_n, mdc, mh, mh_oe, fw_req, fw_addr, fw_len, absent} = '0;
        ds = 3'b101;
        for (int i = 0; i < 65536; i++) u_ee.mem[i] = i[7:0] ^ i[15:8];
        do_reset(1'b1);
        do_reset(1'b0);
        ee_op(16'h1234, 8'ha5, 1'b0, 0);
        chk("mem_write", 16'h00a5, {8'h00, u_ee.mem[16'h1234]});
        ee_op(16'h1236, 8'h00, 1'b1, 32);
        chk("host_read", {8'h00, ex(16'h1236)}, r);
        burst(16'h1233, 1'b0);
        ds = 3'b001;
        burst(16'h1233, 1'b1);
        ds = 3'b101;
        absent = 1'b1;
        ee_op(16'h1234, 8'h77, 1'b0, 0);
        chk("no_update", 16'h00a5, {8'h00, u_ee.mem[16'h1234]});
        burst(16'h0000, 1'b1);
        summarize();
    end
endmodule
